/* File: logic/c8x_core.sv */
// execution core: arithmetic, branches, bit ops, control, jump and call
// Contract
// - arithmetic takes accumulator plus memory or immediate
// - clear, inc, dec reach all 256 bytes
// - complement, rotate, shift act on accumulator only
// - branch taken only when condition holds
// - flag branch span -15 to +16
// - bit-test branch span -126 to +129
// - tested bit into carry, zero kept
// - bit set/clear any bit, flags kept
// - stop becomes wait when watchdog selected
// - jump and call reach whole program space
// - branch opcode holds condition, direction, span
// - opcode bit 4 picks index register
// - target joins opcode nibble with next byte
// - six-entry hardware return stack
`timescale 1ns/100ps
module c8x_core #(
  parameter int STACK_DEPTH = c8x_pkg::STACK_DEPTH
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // program memory
  output logic [11:0] pm_addr_out,
  input wire logic [7:0] pm_data_in,
  // data space
  output logic [7:0] ds_addr_out,
  output logic [7:0] ds_wdata_out,
  output logic ds_we_out,
  input wire logic [7:0] ds_rdata_in,
  // system
  input wire logic irq_in,
  input wire logic wdg_sel_in,
  output logic stop_mode_out,
  output logic wait_mode_out,
  output logic zero_flag_out,
  output logic carry_flag_out,
  output logic [7:0] acc_out
);
  if (STACK_DEPTH < 1 || STACK_DEPTH > 16) begin : g_chk
    $error("stack depth out of range");
  end

  logic [11:0] pc_q, ia_q;
  logic [7:0] opc_q, b1_q, b2_q, opnd_q, acc_q, ds_addr_q, ds_wdata_q;
  logic [7:0] sd_q [4];
  logic [11:0] stack_q [STACK_DEPTH];
  logic [2:0] cyc_q, irq_sync_q, wdg_sync_q;
  logic z_q, c_q, z_sv_q, c_sv_q, in_isr_q, stop_q, wait_q, ds_we_q, irq_q, wdg_q;
  c8x_pkg::c8x_class_t cls;
  logic [1:0] nbytes;
  logic [2:0] ncyc, bitsel;
  logic last, lp, take_irq, cond_ok, bit_val, ex_z, ex_c, ex_acc_we, ex_mem_we;
  logic [7:0] rd_val, ex_acc, ex_mem;
  logic [8:0] sum9, dif9;
  logic [11:0] br_tgt;

  assign pm_addr_out = pc_q;
  assign ds_addr_out = ds_addr_q;
  assign ds_wdata_out = ds_wdata_q;
  assign ds_we_out = ds_we_q;
  assign stop_mode_out = stop_q;
  assign wait_mode_out = wait_q;
  assign zero_flag_out = z_q;
  assign carry_flag_out = c_q;
  assign acc_out = acc_q;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_sync_q <= 3'h0;
      wdg_sync_q <= 3'h0;
      irq_q <= 1'b0;
      wdg_q <= 1'b0;
    end else begin
      irq_sync_q <= {irq_sync_q[1:0], irq_in};
      wdg_sync_q <= {wdg_sync_q[1:0], wdg_sel_in};
      if (irq_sync_q[1] == irq_sync_q[2]) irq_q <= irq_sync_q[2];
      if (wdg_sync_q[1] == wdg_sync_q[2]) wdg_q <= wdg_sync_q[2];
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  assign cls = c8x_pkg::op_class(opc_q);
  assign nbytes = c8x_pkg::op_bytes(opc_q);
  assign ncyc = c8x_pkg::op_cycles(opc_q);
  assign lp = stop_q | wait_q;
  assign last = !lp && (cyc_q != 3'h0) && (cyc_q == ncyc - 3'h1);
  assign take_irq = !lp && (cyc_q == 3'h0) && irq_q && !in_isr_q;
  assign bitsel = {opc_q[5], opc_q[6], opc_q[7]};
  assign bit_val = opnd_q[bitsel];
  assign sum9 = {1'b0, acc_q} + {1'b0, opnd_q};
  assign dif9 = {1'b0, acc_q} - {1'b0, opnd_q};
  assign rd_val = (ds_addr_q == c8x_pkg::ADDR_ACC) ? acc_q :
                  (ds_addr_q[7:2] == c8x_pkg::ADDR_X[7:2]) ? sd_q[ds_addr_q[1:0]] : ds_rdata_in;

  always_comb begin
    case (opc_q[2:1])
      2'h0: cond_ok = !z_q;
      2'h1: cond_ok = !c_q;
      2'h2: cond_ok = z_q;
      default: cond_ok = c_q;
    endcase
    if (cls == c8x_pkg::CL_BTEST) cond_ok = (bit_val == opc_q[4]);
  end

  assign br_tgt = (cls == c8x_pkg::CL_BTEST) ?
                  ia_q + c8x_pkg::BTEST_BASE + {{4{b2_q[7]}}, b2_q} :
                  ia_q + c8x_pkg::FLAG_BASE + {{7{opc_q[7]}}, opc_q[7:3]};

  // ----------------------------------------
  // execution results
  // ----------------------------------------
  always_comb begin
    ex_z = z_q;
    ex_c = c_q;
    ex_acc_we = 1'b0;
    ex_acc = acc_q;
    ex_mem_we = 1'b0;
    ex_mem = opnd_q;
    case (cls)
      c8x_pkg::CL_ALU: begin
        case (opc_q[7:5])
          c8x_pkg::ALU_CP: begin
            ex_z = (dif9[7:0] == 8'h00);
            ex_c = dif9[8];
          end
          c8x_pkg::ALU_ADD, c8x_pkg::ALU_SUB: begin
            ex_acc_we = 1'b1;
            ex_acc = opc_q[7] ? dif9[7:0] : sum9[7:0];
            ex_z = (ex_acc == 8'h00);
            ex_c = opc_q[7] ? dif9[8] : sum9[8];
          end
          c8x_pkg::ALU_AND: begin
            ex_acc_we = 1'b1;
            ex_acc = acc_q & opnd_q;
            ex_z = (ex_acc == 8'h00);
          end
          c8x_pkg::ALU_INC, c8x_pkg::ALU_DEC: begin
            ex_mem_we = !(opc_q[3] && opc_q[4]);
            ex_mem = opc_q[7] ? opnd_q - 8'h01 : opnd_q + 8'h01;
            ex_z = ex_mem_we ? (ex_mem == 8'h00) : z_q;
          end
          default: ;
        endcase
      end
      c8x_pkg::CL_SHORT: begin
        ex_mem_we = 1'b1;
        ex_mem = opc_q[5] ? opnd_q - 8'h01 : opnd_q + 8'h01;
        ex_z = (ex_mem == 8'h00);
      end
      c8x_pkg::CL_ACCU: begin
        case (opc_q[7:4])
          c8x_pkg::ACC_COM, c8x_pkg::ACC_RLC, c8x_pkg::ACC_SLA: begin
            ex_acc_we = 1'b1;
            ex_c = acc_q[7];
            if (opc_q[7:4] == c8x_pkg::ACC_COM) ex_acc = ~acc_q;
            else ex_acc = {acc_q[6:0], (opc_q[7:4] == c8x_pkg::ACC_RLC) & c_q};
            ex_z = (ex_acc == 8'h00);
          end
          c8x_pkg::ACC_CLRA: begin
            ex_acc_we = 1'b1;
            ex_acc = 8'h00;
            ex_z = 1'b1;
            ex_c = 1'b0;
          end
          c8x_pkg::ACC_CLRM: begin
            ex_mem_we = 1'b1;
            ex_mem = 8'h00;
          end
          default: ;
        endcase
      end
      c8x_pkg::CL_BITMOD: begin
        ex_mem_we = 1'b1;
        ex_mem[bitsel] = opc_q[4];
      end
      c8x_pkg::CL_BTEST: ex_c = bit_val;
      c8x_pkg::CL_CTRL: begin
        if (opc_q[7:5] == c8x_pkg::CTRL_RETURN_FROM_INTERRUPT) begin
          ex_z = z_sv_q;
          ex_c = c_sv_q;
        end
      end
      default: ;
    endcase
  end

  // ----------------------------------------
  // sequencing, program counter and stack
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_q <= c8x_pkg::PC_RESET;
      ia_q <= c8x_pkg::PC_RESET;
      opc_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      cyc_q <= 3'h0;
      in_isr_q <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++) stack_q[i] <= 12'h000;
    end else if (take_irq) begin
      for (int i = STACK_DEPTH - 1; i > 0; i--) stack_q[i] <= stack_q[i - 1];
      stack_q[0] <= pc_q;
      pc_q <= c8x_pkg::ISR_VECTOR;
      in_isr_q <= 1'b1;
    end else if (!lp && cyc_q == 3'h0) begin
      opc_q <= pm_data_in;
      ia_q <= pc_q;
      pc_q <= pc_q + 12'h001;
      cyc_q <= 3'h1;
    end else if (!lp) begin
      cyc_q <= last ? 3'h0 : cyc_q + 3'h1;
      if ((cyc_q == 3'h1 && nbytes > 2'h1) || (cyc_q == 3'h2 && nbytes > 2'h2)) pc_q <= pc_q + 12'h001;
      if (cyc_q == 3'h1) b1_q <= pm_data_in;
      if (cyc_q == 3'h2) b2_q <= pm_data_in;
      if (last) begin
        case (cls)
          c8x_pkg::CL_BRANCH, c8x_pkg::CL_BTEST: if (cond_ok) pc_q <= br_tgt;
          c8x_pkg::CL_CALLJP: begin
            pc_q <= {opc_q[7:4], b1_q};
            if (!opc_q[3]) begin
              for (int i = STACK_DEPTH - 1; i > 0; i--) stack_q[i] <= stack_q[i - 1];
              stack_q[0] <= pc_q;
            end
          end
          c8x_pkg::CL_CTRL: begin
            if (opc_q[7:5] == c8x_pkg::CTRL_RET || opc_q[7:5] == c8x_pkg::CTRL_RETURN_FROM_INTERRUPT) begin
              pc_q <= stack_q[0];
              for (int i = 0; i < STACK_DEPTH - 1; i++) stack_q[i] <= stack_q[i + 1];
              stack_q[STACK_DEPTH - 1] <= 12'h000;
            end
            if (opc_q[7:5] == c8x_pkg::CTRL_RETURN_FROM_INTERRUPT) in_isr_q <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // data path and flags
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_q <= 8'h00;
      for (int i = 0; i < 4; i++) sd_q[i] <= 8'h00;
      {z_q, c_q, z_sv_q, c_sv_q, ds_we_q} <= 5'h00;
      ds_addr_q <= 8'h00;
      ds_wdata_q <= 8'h00;
      opnd_q <= 8'h00;
    end else begin
      ds_we_q <= 1'b0;
      if (take_irq) begin
        z_sv_q <= z_q;
        c_sv_q <= c_q;
      end
      if (!lp && cyc_q == 3'h1) begin
        case (cls)
          c8x_pkg::CL_ALU: begin
            if (!opc_q[3]) ds_addr_q <= sd_q[{1'b0, opc_q[4]}];
            else if (opc_q[4]) opnd_q <= pm_data_in;
            else ds_addr_q <= pm_data_in;
          end
          c8x_pkg::CL_SHORT: ds_addr_q <= {c8x_pkg::ADDR_X[7:2], opc_q[7:6]};
          c8x_pkg::CL_BTEST, c8x_pkg::CL_BITMOD, c8x_pkg::CL_ACCU: ds_addr_q <= pm_data_in;
          default: ;
        endcase
      end
      if (!lp && cyc_q == 3'h2 && !(cls == c8x_pkg::CL_ALU && opc_q[3] && opc_q[4])) opnd_q <= rd_val;
      if (last) begin
        z_q <= ex_z;
        c_q <= ex_c;
        if (ex_acc_we) acc_q <= ex_acc;
        if (ex_mem_we) begin
          if (ds_addr_q == c8x_pkg::ADDR_ACC) acc_q <= ex_mem;
          else if (ds_addr_q[7:2] == c8x_pkg::ADDR_X[7:2]) sd_q[ds_addr_q[1:0]] <= ex_mem;
          else begin
            ds_we_q <= 1'b1;
            ds_wdata_q <= ex_mem;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // low-power entry and wake
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stop_q <= 1'b0;
      wait_q <= 1'b0;
    end else if (lp) begin
      if (irq_q) {stop_q, wait_q} <= 2'h0;
    end else if (last && cls == c8x_pkg::CL_CTRL) begin
      if (opc_q[7:5] == c8x_pkg::CTRL_STOP) begin
        if (wdg_q) wait_q <= 1'b1;
        else stop_q <= 1'b1;
      end
      if (opc_q[7:5] == c8x_pkg::CTRL_WAIT) wait_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  alu_len_a:
  assert property (cyc_q == 3'h1 && !lp && cls == c8x_pkg::CL_ALU |-> ##1 cyc_q == 3'h2 ##1 cyc_q == 3'h3 ##1 cyc_q == 3'h0)
    else $error("arithmetic length wrong");
  btest_len_a:
  assert property (cyc_q == 3'h1 && !lp && cls == c8x_pkg::CL_BTEST |-> ##3 last ##1 cyc_q == 3'h0)
    else $error("bit-test length wrong");
  no_take_a:
  assert property (last && cls == c8x_pkg::CL_BRANCH && !cond_ok |=> pc_q == ia_q + 12'h001)
    else $error("untaken branch moved");
  flag_span_a:
  assert property (last && cls == c8x_pkg::CL_BRANCH && cond_ok |=> 12'(pc_q - ia_q + 12'h00f) <= 12'h01f)
    else $error("flag branch span");
  btest_span_a:
  assert property (last && cls == c8x_pkg::CL_BTEST && cond_ok |=> 12'(pc_q - ia_q + 12'h07e) <= 12'h0ff)
    else $error("bit-test span");
  btest_carry_a:
  assert property (last && cls == c8x_pkg::CL_BTEST |=> c_q == $past(bit_val) && $stable(z_q))
    else $error("tested bit not in carry");
  bitmod_flags_a:
  assert property (last && cls == c8x_pkg::CL_BITMOD |=> $stable(z_q) && $stable(c_q))
    else $error("bit op touched flags");
  stop_wdg_a:
  assert property (last && cls == c8x_pkg::CL_CTRL && opc_q[7:5] == c8x_pkg::CTRL_STOP && wdg_q |=> wait_q && !stop_q)
    else $error("stop entered under watchdog");
  jump_tgt_a:
  assert property (last && cls == c8x_pkg::CL_CALLJP |=> pc_q == {$past(opc_q[7:4]), $past(b1_q)})
    else $error("long target wrong");
  call_push_a:
  assert property (last && cls == c8x_pkg::CL_CALLJP && !opc_q[3] |=> stack_q[0] == ia_q + 12'h002)
    else $error("call return address");
  return_from_interrupt_flags_a:
  assert property (last && cls == c8x_pkg::CL_CTRL && opc_q[7:5] == c8x_pkg::CTRL_RETURN_FROM_INTERRUPT |=> z_q == $past(z_sv_q) && c_q == $past(c_sv_q))
    else $error("flags not restored");
  acc_only_a:
  assert property (last && cls == c8x_pkg::CL_ACCU && opc_q[7:4] < c8x_pkg::ACC_CLRA |=> !ds_we_q)
    else $error("accumulator op wrote memory");
  idx_sel_a:
  assert property (cyc_q == 3'h1 && !lp && cls == c8x_pkg::CL_ALU && !opc_q[3] |=> ds_addr_q == $past(sd_q[{1'b0, opc_q[4]}]))
    else $error("index register choice");

  br_taken_c: cover property (last && cls == c8x_pkg::CL_BRANCH && cond_ok);
  btest_taken_c: cover property (last && cls == c8x_pkg::CL_BTEST && cond_ok);
  irq_entry_c: cover property (take_irq);
  wait_entry_c: cover property (!wait_q ##1 wait_q);
endmodule // c8x_core

/* File: inc/c8x_pkg.sv */
// constants, instruction classes and decode helpers for the 8-bit core
package c8x_pkg;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [11:0] ISR_VECTOR = 12'hff0;
  localparam logic [7:0] ADDR_X = 8'h80;
  localparam logic [7:0] ADDR_ACC = 8'hff;
  localparam logic [11:0] FLAG_BASE = 12'h001;
  localparam logic [11:0] BTEST_BASE = 12'h002;
  localparam logic [2:0] CYC_SHORT = 3'h2;
  localparam logic [2:0] CYC_BTEST = 3'h5;
  localparam logic [2:0] CYC_LONG = 3'h4;
  localparam int STACK_DEPTH = 6;
  localparam logic [2:0] ALU_CP = 3'h1;
  localparam logic [2:0] ALU_ADD = 3'h2;
  localparam logic [2:0] ALU_INC = 3'h3;
  localparam logic [2:0] ALU_AND = 3'h5;
  localparam logic [2:0] ALU_SUB = 3'h6;
  localparam logic [2:0] ALU_DEC = 3'h7;
  localparam logic [3:0] ACC_COM = 4'h0;
  localparam logic [3:0] ACC_RLC = 4'h1;
  localparam logic [3:0] ACC_SLA = 4'h2;
  localparam logic [3:0] ACC_CLRA = 4'h3;
  localparam logic [3:0] ACC_CLRM = 4'h4;
  localparam logic [2:0] CTRL_RET = 3'h1;
  localparam logic [2:0] CTRL_RETURN_FROM_INTERRUPT = 3'h2;
  localparam logic [2:0] CTRL_STOP = 3'h3;
  localparam logic [2:0] CTRL_WAIT = 3'h4;

  typedef enum logic [2:0] {CL_BRANCH, CL_CALLJP, CL_BTEST, CL_BITMOD, CL_CTRL, CL_ACCU, CL_SHORT, CL_ALU} c8x_class_t;

  function automatic c8x_class_t op_class(input logic [7:0] op);
    c8x_class_t cl;
    cl = CL_ALU;
    if (!op[0]) cl = CL_BRANCH;
    else case (op[2:1])
      2'h0: cl = CL_CALLJP;
      2'h1: cl = op[3] ? CL_BITMOD : CL_BTEST;
      2'h2: cl = op[3] ? CL_ACCU : (op[4] ? CL_SHORT : CL_CTRL);
      default: cl = CL_ALU;
    endcase
    return cl;
  endfunction

  function automatic logic [1:0] op_bytes(input logic [7:0] op);
    case (op_class(op))
      CL_BTEST: return 2'h3;
      CL_CALLJP, CL_BITMOD: return 2'h2;
      CL_ACCU: return (op[7:4] == ACC_CLRM) ? 2'h2 : 2'h1;
      CL_ALU: return op[3] ? 2'h2 : 2'h1;
      default: return 2'h1;
    endcase
  endfunction

  function automatic logic [2:0] op_cycles(input logic [7:0] op);
    case (op_class(op))
      CL_BRANCH, CL_CTRL: return CYC_SHORT;
      CL_BTEST: return CYC_BTEST;
      default: return CYC_LONG;
    endcase
  endfunction
endpackage

/* File: tb/c8x_mem_model.sv */
// partner model: program rom and data-space ram facing the core
`timescale 1ns/100ps
module c8x_mem_model (
  // clock
  input wire logic sys_clk_in,
  // program memory
  input wire logic [11:0] pm_addr_in,
  output logic [7:0] pm_data_out,
  // data space
  input wire logic [7:0] ds_addr_in,
  input wire logic [7:0] ds_wdata_in,
  input wire logic ds_we_in,
  output logic [7:0] ds_rdata_out
);
  // ----------------------------------------
  // storage, loaded by the bench under reset
  // ----------------------------------------
  logic [7:0] rom [4096];
  logic [7:0] ram [256];

  initial begin
    foreach (rom[j]) rom[j] = 8'h00;
    foreach (ram[j]) ram[j] = 8'h00;
  end

  // same-cycle answers, as the core samples within the cycle
  assign pm_data_out = rom[pm_addr_in];
  assign ds_rdata_out = ram[ds_addr_in];

  always @(posedge sys_clk_in) begin
    if (ds_we_in) ram[ds_addr_in] <= ds_wdata_in;
  end
endmodule // c8x_mem_model

/* File: tb/tb_c8x_core.sv */
// self-checking bench for the execution core with random operands
`timescale 1ns/100ps
module tb_c8x_core;
  logic sys_clk_in, reset_n_in, irq_in, wdg_sel_in;
  logic ds_we_out, stop_mode_out, wait_mode_out, zero_flag_out, carry_flag_out;
  logic [11:0] pm_addr_out, wp;
  logic [7:0] pm_data_in, ds_addr_out, ds_wdata_out, ds_rdata_in, acc_out;
  logic [7:0] p, q, b, r, v, e, loc;
  logic [2:0] code [6];
  logic [11:0] tt [7];
  logic [17:0] res;
  logic zc, cc, tk;
  int fail_count, checks, i, k, m, mm;

  c8x_core dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .pm_addr_out(pm_addr_out),
    .pm_data_in(pm_data_in), .ds_addr_out(ds_addr_out), .ds_wdata_out(ds_wdata_out), .ds_we_out(ds_we_out),
    .ds_rdata_in(ds_rdata_in), .irq_in(irq_in), .wdg_sel_in(wdg_sel_in), .stop_mode_out(stop_mode_out),
    .wait_mode_out(wait_mode_out), .zero_flag_out(zero_flag_out), .carry_flag_out(carry_flag_out),
    .acc_out(acc_out));

  c8x_mem_model mem (.sys_clk_in(sys_clk_in), .pm_addr_in(pm_addr_out), .pm_data_out(pm_data_in),
    .ds_addr_in(ds_addr_out), .ds_wdata_in(ds_wdata_out), .ds_we_in(ds_we_out), .ds_rdata_out(ds_rdata_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic put(input logic [7:0] x);
    mem.rom[wp] = x;
    wp++;
  endtask

  task automatic run_to(input logic [11:0] a);
    int n;
    n = 0;
    while (pm_addr_out !== a) begin
      @(negedge sys_clk_in);
      n++;
      if (n > 2000) begin
        fail_count++;
        tally_and_finish();
      end
    end
  endtask

  task automatic step(input int n, input logic [11:0] a);
    repeat (n) @(negedge sys_clk_in);
    check(pm_addr_out, a);
  endtask

  // index regs x=1 y=2, acc=pp+qq, then jump to 100h
  task automatic prefix(input logic [7:0] pp, input logic [7:0] qq);
    logic [7:0] pre [14];
    logic [8:0] s;
    @(negedge sys_clk_in);
    reset_n_in = 1'b0;
    pre = '{8'h4D, 8'h80, 8'h15, 8'h4D, 8'h81, 8'h55, 8'h55, 8'h3D, 8'h5F, pp, 8'h5F, qq, 8'h19, 8'h00};
    wp = 12'h000;
    foreach (pre[j]) put(pre[j]);
    s = {1'b0, pp} + {1'b0, qq};
    cc = s[8];
    zc = (s[7:0] == 8'h00);
    wp = 12'h100;
  endtask

  task automatic launch();
    repeat (5) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    run_to(12'h100);
  endtask

  // expected {acc, mem, z, c}
  function automatic logic [17:0] model_op(input int k, input logic [7:0] a, input logic [7:0] b,
                                           input logic z, input logic c);
    logic [8:0] s;
    logic [7:0] acc, mv;
    acc = a;
    mv = b;
    case (k)
      0, 3: s = {1'b0, a} - {1'b0, b};
      1: s = {1'b0, a} + {1'b0, b};
      2: s = {c, a & b};
      4: s = {c, b + 8'h01};
      5: s = {c, b - 8'h01};
      6: s = {a[7], ~a};
      7: s = {a[7], a[6:0], c};
      9: s = {c, 8'h00};
      default: s = {a[7], a[6:0], 1'b0};
    endcase
    if (k == 4 || k == 5 || k == 9) mv = s[7:0];
    else if (k != 0) acc = s[7:0];
    return {acc, mv, (k == 9) ? z : (s[7:0] == 8'h00), s[8]};
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    reset_n_in = 1'b0;
    irq_in = 1'b0;
    wdg_sel_in = 1'b0;
    void'($urandom(73816));
    code = '{c8x_pkg::ALU_CP, c8x_pkg::ALU_ADD, c8x_pkg::ALU_AND, c8x_pkg::ALU_SUB, c8x_pkg::ALU_INC,
             c8x_pkg::ALU_DEC};
    // arithmetic, accumulator ops and memory clear; every operand mode but immediate for inc/dec, direct only for clear
    for (k = 0; k < 10; k++) begin
      for (m = 0; m < 4; m++) begin
        mm = ((k > 3 && k < 6 && m == 0) || k == 9) ? 1 : m;
        p = 8'($urandom);
        q = (m == 0) ? 8'h00 : 8'($urandom);
        b = (m == 3) ? p + q : 8'($urandom);
        r = 8'($urandom % 251) | 8'h04;
        loc = (mm == 1) ? r : {6'h00, 2'(mm - 1)};
        prefix(p, q);
        mem.ram[1] = ~b;
        mem.ram[2] = ~b;
        mem.ram[r] = ~b;
        mem.ram[loc] = b;
        put(k < 6 ? {code[k], mm == 0 || mm == 3, mm < 2, 3'b111} : (k == 9) ? 8'h4D : {4'(k - 6), 4'hD});
        if ((k < 6 || k == 9) && mm < 2) put(mm == 0 ? b : r);
        put(8'h19);
        put(8'h60);
        launch();
        step(8, 12'h160);
        res = model_op(k, p + q, b, zc, cc);
        check(acc_out, res[17:10]);
        check(mem.ram[loc], res[9:2]);
        check(zero_flag_out, res[1]);
        check(carry_flag_out, res[0]);
      end
    end
    // flag branches, all conditions and flag states
    for (i = 0; i < 16; i++) begin
      q = (i[3:2] == 2'h3) ? 8'h01 : {8{i[3:2] != 2'h0}};
      e = (i == 0) ? 8'h10 : (i == 1) ? 8'h0F : 8'(1 + $urandom % 31);
      prefix(8'(i[3:2]), q);
      put({e[4:0], 2'(i), 1'b0});
      launch();
      tk = i[1] ? (i[0] ? cc : zc) : ~(i[0] ? cc : zc);
      step(2, tk ? 12'h101 + {{7{e[4]}}, e[4:0]} : 12'h101);
      check({zero_flag_out, carry_flag_out}, {zc, cc});
    end
    // bit test branch, then bit set or clear on the same byte
    for (i = 0; i < 16; i++) begin
      v = 8'($urandom);
      // bit ops on plain ram only
      r = 8'($urandom % 251) | 8'h04;
      e = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($urandom);
      p = 8'($urandom);
      q = 8'($urandom);
      prefix(p, q);
      mem.ram[r] = v;
      put({i[0], i[1], i[2], i[3], 4'h3});
      put(r);
      put(e);
      launch();
      step(5, (v[i[2:0]] == i[3]) ? 12'h102 + {{4{e[7]}}, e} : 12'h103);
      check({zero_flag_out, carry_flag_out}, {zc, v[i[2:0]]});
      prefix(p, q);
      put({i[0], i[1], i[2], i[3], 4'hB});
      put(r);
      put(8'h19);
      put(8'h60);
      launch();
      step(8, 12'h160);
      check(mem.ram[r], i[3] ? v | (8'h01 << i[2:0]) : v & ~(8'h01 << i[2:0]));
      check({zero_flag_out, carry_flag_out}, {zc, cc});
    end
    // six nested calls across program space, then returns
    prefix(8'($urandom), 8'($urandom));
    tt[0] = 12'h100;
    for (k = 1; k < 7; k++) tt[k] = {4'(2 * k + 3), 8'($urandom)};
    for (k = 0; k < 6; k++) begin
      wp = tt[k];
      put({tt[k + 1][11:8], 4'h1});
      put(tt[k + 1][7:0]);
      put(8'h25);
    end
    wp = tt[6];
    put(8'h25);
    launch();
    for (k = 1; k < 7; k++) step(4, tt[k]);
    for (k = 5; k >= 0; k--) step(2, tt[k] + 12'h002);
    check({zero_flag_out, carry_flag_out}, {zc, cc});
    // low power entry, wake by interrupt, flags restored
    for (i = 0; i < 3; i++) begin
      wdg_sel_in = (i == 1);
      prefix(8'($urandom), 8'($urandom));
      put(i == 2 ? 8'h85 : 8'h65);
      wp = c8x_pkg::ISR_VECTOR;
      put(8'h3D);
      put(8'h45);
      launch();
      step(6, 12'h101);
      check({stop_mode_out, wait_mode_out}, {i == 0, i != 0});
      irq_in = 1'b1;
      run_to(c8x_pkg::ISR_VECTOR);
      irq_in = 1'b0;
      step(6, 12'h101);
      check({zero_flag_out, carry_flag_out}, {zc, cc});
    end
    tally_and_finish();
  end
endmodule // tb_c8x_core
